// File: dma_cmd_pkg.sv
// Constants shared by the DMA cell command, pointer, status and interrupt
// logic. Assumes every user writes package::name and nothing is imported.
package dma_cmd_pkg;

    // Data width of the byte-wide host register port.
    localparam int DATA_W = 8;
    // Number of DMA channels handled by this block.
    localparam int CHAN_N = 4;
    // Width of the indirect register pointer.
    localparam int PTR_W = 5;

    // Channel bit positions inside every four-bit channel vector.
    localparam int CH_RXA = 3;
    localparam int CH_TXA = 2;
    localparam int CH_RXB = 1;
    localparam int CH_TXB = 0;

    // Register indices selected through the pointer.
    localparam logic [4:0] IDX_COMMAND = 5'h00;
    localparam logic [4:0] IDX_INT_SETUP = 5'h01;
    localparam logic [4:0] IDX_VECTOR = 5'h02;
    localparam logic [4:0] IDX_CHAN_STATE = 5'h03;

    // Command field position in the command register.
    localparam int CMD_LSB = 5;
    localparam int CMD_MSB = 7;

    // Command codes.
    localparam logic [2:0] CMD_NULL = 3'h0;
    localparam logic [2:0] CMD_RESERVED = 3'h1;
    localparam logic [2:0] CMD_RESET_HIGH_IUS = 3'h2;
    localparam logic [2:0] CMD_RESET_CELL = 3'h3;
    localparam logic [2:0] CMD_EN_TXB = 3'h4;
    localparam logic [2:0] CMD_EN_RXB = 3'h5;
    localparam logic [2:0] CMD_EN_TXA = 3'h6;
    localparam logic [2:0] CMD_EN_RXA = 3'h7;

    // Interrupt setup register field positions.
    localparam int SETUP_GATE_BIT = 7;
    localparam int SETUP_BLOCK_BIT = 6;
    localparam int SETUP_NOVEC_BIT = 5;
    localparam int SETUP_VIS_BIT = 4;
    localparam int SETUP_IE_MSB = 3;

    // Vector status field position.
    localparam int VEC_STAT_LSB = 1;
    localparam int VEC_STAT_MSB = 3;

    // Vector status codes.
    localparam logic [2:0] VCODE_NONE = 3'h0;
    localparam logic [2:0] VCODE_RXA = 3'h4;
    localparam logic [2:0] VCODE_RXB = 3'h5;
    localparam logic [2:0] VCODE_TXA = 3'h6;
    localparam logic [2:0] VCODE_TXB = 3'h7;

    // Reset values.
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [7:0] VECTOR_RST = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [4:0] PTR_RST = 5'h00;
    localparam logic [3:0] CHAN_RST = 4'h0;

endpackage

// File: dma_sticky_flags.sv
// A bank of sticky flags that hardware sets and a command or read clears.
// Assumes set and clear are single-cycle strobes synchronous to i_mclk.
`timescale 1ns/1ns
module dma_sticky_flags #(
    parameter int WIDTH = 4
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_set,
    input wire logic [WIDTH-1:0] i_clr,
    output logic [WIDTH-1:0] o_flags
);

    // Each flag is its own flip-flop; a set arriving with a clear wins,
    // so an event that lands during a clearing read is never lost.
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_flag
            logic next_flag;
            assign next_flag = i_set[b] | (o_flags[b] & ~i_clr[b]);
            always_ff @(posedge i_mclk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    o_flags[b] <= 1'b0;
                end else if (i_ce) begin
                    o_flags[b] <= next_flag;
                end
            end
        end
    endgenerate

endmodule

// File: dma_fixed_priority.sv
// Fixed-priority picker over the four DMA channels, receive A highest.
// Assumes the channel order of the package: bit 3 receive A down to bit 0.
`timescale 1ns/1ns
module dma_fixed_priority (
    input wire logic [3:0] i_req,
    output logic [3:0] o_grant,
    output logic [2:0] o_code,
    output logic o_any
);

    // One-hot grant of the highest set request.
    assign o_grant[dma_cmd_pkg::CH_RXA] = i_req[dma_cmd_pkg::CH_RXA];
    assign o_grant[dma_cmd_pkg::CH_TXA] = i_req[dma_cmd_pkg::CH_TXA]
        & ~i_req[dma_cmd_pkg::CH_RXA];
    assign o_grant[dma_cmd_pkg::CH_RXB] = i_req[dma_cmd_pkg::CH_RXB]
        & ~i_req[dma_cmd_pkg::CH_RXA] & ~i_req[dma_cmd_pkg::CH_TXA];
    assign o_grant[dma_cmd_pkg::CH_TXB] = i_req[dma_cmd_pkg::CH_TXB]
        & ~i_req[dma_cmd_pkg::CH_RXA] & ~i_req[dma_cmd_pkg::CH_TXA]
        & ~i_req[dma_cmd_pkg::CH_RXB];
    assign o_any = |i_req;

    // Vector status code of the winner; note the code order differs from
    // the priority order, so it is a lookup rather than an index.
    assign o_code = o_grant[dma_cmd_pkg::CH_RXA] ? dma_cmd_pkg::VCODE_RXA :
                    o_grant[dma_cmd_pkg::CH_TXA] ? dma_cmd_pkg::VCODE_TXA :
                    o_grant[dma_cmd_pkg::CH_RXB] ? dma_cmd_pkg::VCODE_RXB :
                    o_grant[dma_cmd_pkg::CH_TXB] ? dma_cmd_pkg::VCODE_TXB :
                    dma_cmd_pkg::VCODE_NONE;

endmodule

// File: dma_cell_command_interrupt.sv
// Command, pointer, status and interrupt logic of a four-channel DMA cell.
// Assumes a byte-wide host port whose strobes are one-cycle pulses on
// i_mclk, and a datapath that reports terminal count, abort and interrupt
// events as one-cycle pulses. Channel order is receive A at bit 3 down to
// transmit B at bit 0.
`timescale 1ns/1ns
module dma_cell_command_interrupt #(
    parameter int CHANNELS = 4
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // Host register port: one-cycle strobes, data sampled with them.
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    // Interrupt acknowledge vector phase strobe.
    input wire logic i_intack,
    // Daisy-chain enable from the higher-priority neighbour.
    input wire logic i_chain_enable_in,
    // Datapath events, one-cycle pulses per channel.
    input wire logic [3:0] i_tc_event,
    input wire logic [3:0] i_abort_event,
    input wire logic [3:0] i_irq_event,
    // Read data or vector and its drive enable.
    output logic [7:0] o_data,
    output logic o_data_oe,
    // Interrupt request and daisy-chain enable to lower devices.
    output logic o_irq,
    output logic o_chain_enable_out,
    // Channel enables handed to the datapath.
    output logic [3:0] o_chan_enable
);

    // Indirect register pointer; zero selects the command register.
    logic [4:0] ptr;
    // Interrupt setup register: gate, chain block, no vector, status, IEs.
    logic [7:0] int_setup;
    // Programmed vector base.
    logic [7:0] vector_base;
    // Terminal count and abort flags as the status register shows them.
    logic [7:0] status_flags;
    // Per-channel pending and in-service flags.
    logic [3:0] pending_flag;
    logic [3:0] in_service_flag;

    // Decoded setup fields.
    logic global_irq_gate;
    logic lower_chain_block;
    logic no_vector;
    logic vector_incl_status;
    logic [3:0] chan_irq_en;
    assign global_irq_gate = int_setup[dma_cmd_pkg::SETUP_GATE_BIT];
    assign lower_chain_block = int_setup[dma_cmd_pkg::SETUP_BLOCK_BIT];
    assign no_vector = int_setup[dma_cmd_pkg::SETUP_NOVEC_BIT];
    assign vector_incl_status = int_setup[dma_cmd_pkg::SETUP_VIS_BIT];
    assign chan_irq_en = int_setup[dma_cmd_pkg::SETUP_IE_MSB:0];

    // Host access decode against the current pointer.
    logic ptr_at_cmd;
    logic wr_cmd;
    logic rd_status;
    logic wr_setup;
    logic wr_vector;
    logic any_access;
    assign ptr_at_cmd = (ptr == dma_cmd_pkg::IDX_COMMAND);
    assign wr_cmd = i_wr & ptr_at_cmd;
    assign rd_status = i_rd & ptr_at_cmd;
    assign wr_setup = i_wr & (ptr == dma_cmd_pkg::IDX_INT_SETUP);
    assign wr_vector = i_wr & (ptr == dma_cmd_pkg::IDX_VECTOR);
    assign any_access = i_wr | i_rd;

    // Command field of a command write.
    logic [2:0] cmd_code;
    logic cmd_reset_cell;
    logic cmd_reset_ius;
    assign cmd_code = i_wdata[dma_cmd_pkg::CMD_MSB:dma_cmd_pkg::CMD_LSB];
    assign cmd_reset_cell = wr_cmd
        & (cmd_code == dma_cmd_pkg::CMD_RESET_CELL);
    assign cmd_reset_ius = wr_cmd
        & (cmd_code == dma_cmd_pkg::CMD_RESET_HIGH_IUS);

    // Interrupt arbitration: pending and enabled sources, fixed order.
    logic [3:0] irq_req;
    logic [3:0] irq_grant;
    logic [2:0] irq_code;
    logic irq_any;
    assign irq_req = pending_flag & chan_irq_en;

    dma_fixed_priority u_irq_pick (
        .i_req(irq_req),
        .o_grant(irq_grant),
        .o_code(irq_code),
        .o_any(irq_any)
    );

    // Highest set in-service flag, for the reset-highest command.
    logic [3:0] ius_grant;

    dma_fixed_priority u_ius_pick (
        .i_req(in_service_flag),
        .o_grant(ius_grant),
        .o_code(),
        .o_any()
    );

    // Acknowledge is ours only with the chain open and the gate set.
    logic ack_ours;
    assign ack_ours = i_intack & i_chain_enable_in & global_irq_gate
        & irq_any;

    // Vector returned on acknowledge, with optional status substitution.
    logic [7:0] ack_vector;
    assign ack_vector = vector_incl_status
        ? {vector_base[7:dma_cmd_pkg::VEC_STAT_MSB + 1], irq_code,
           vector_base[dma_cmd_pkg::VEC_STAT_LSB - 1:0]}
        : vector_base;

    // Interrupt request: any enabled pending source not yet in service,
    // only while the gate is set and the chain above us is quiet.
    assign o_irq = global_irq_gate & i_chain_enable_in
        & (|(irq_req & ~in_service_flag));

    // Chain output drops while any channel is pending or in service, so
    // lower devices cannot respond during our service routine.
    assign o_chain_enable_out = i_chain_enable_in & ~lower_chain_block
        & ~(|pending_flag) & ~(|in_service_flag);

    // Status flags: terminal count high nibble, abort low nibble. A read
    // clears them but a same-cycle event still lands.
    logic [7:0] status_set;
    logic [7:0] status_clr;
    assign status_set = {i_tc_event, i_abort_event};
    assign status_clr = {8{rd_status | cmd_reset_cell}};

    dma_sticky_flags #(
        .WIDTH(8)
    ) u_status (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_set(status_set),
        .i_clr(status_clr),
        .o_flags(status_flags)
    );

    // Pending flags: set by datapath events, cleared when acknowledged or
    // when the cell is reset.
    logic [3:0] pend_clr;
    assign pend_clr = (ack_ours ? irq_grant : dma_cmd_pkg::CHAN_RST)
        | {4{cmd_reset_cell}};

    dma_sticky_flags #(
        .WIDTH(4)
    ) u_pending (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_set(i_irq_event),
        .i_clr(pend_clr),
        .o_flags(pending_flag)
    );

    // In-service flags: set by our acknowledge, cleared by the reset
    // highest command regardless of the chain input, or by a cell reset.
    logic [3:0] ius_set;
    logic [3:0] ius_clr;
    assign ius_set = ack_ours ? irq_grant : dma_cmd_pkg::CHAN_RST;
    assign ius_clr = (cmd_reset_ius ? ius_grant : dma_cmd_pkg::CHAN_RST)
        | {4{cmd_reset_cell}};

    dma_sticky_flags #(
        .WIDTH(4)
    ) u_in_service (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_set(ius_set),
        .i_clr(ius_clr),
        .o_flags(in_service_flag)
    );

    // Next channel enables from the command field. Enabling never starts
    // a transfer here; the datapath only sees the level.
    logic [3:0] next_chan_enable;
    always_comb begin
        next_chan_enable = o_chan_enable;
        if (wr_cmd) begin
            case (cmd_code)
                dma_cmd_pkg::CMD_NULL: begin
                    next_chan_enable = o_chan_enable;
                end
                dma_cmd_pkg::CMD_RESET_CELL: begin
                    next_chan_enable = dma_cmd_pkg::CHAN_RST;
                end
                dma_cmd_pkg::CMD_EN_TXB: begin
                    next_chan_enable[dma_cmd_pkg::CH_TXB] = 1'b1;
                end
                dma_cmd_pkg::CMD_EN_RXB: begin
                    next_chan_enable[dma_cmd_pkg::CH_RXB] = 1'b1;
                end
                dma_cmd_pkg::CMD_EN_TXA: begin
                    next_chan_enable[dma_cmd_pkg::CH_TXA] = 1'b1;
                end
                dma_cmd_pkg::CMD_EN_RXA: begin
                    next_chan_enable[dma_cmd_pkg::CH_RXA] = 1'b1;
                end
                default: begin
                    // Reserved code and reset-highest leave enables alone.
                    next_chan_enable = o_chan_enable;
                end
            endcase
        end
    end

    // Channel enable register.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_chan_enable <= dma_cmd_pkg::CHAN_RST;
        end else if (i_ce) begin
            o_chan_enable <= next_chan_enable;
        end
    end

    // Pointer: a command write loads it, any access through it clears it.
    logic [4:0] next_ptr;
    assign next_ptr = wr_cmd ? i_wdata[4:0]
        : (any_access ? dma_cmd_pkg::PTR_RST : ptr);

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ptr <= dma_cmd_pkg::PTR_RST;
        end else if (i_ce) begin
            ptr <= next_ptr;
        end
    end

    // Setup and vector registers, written only through the pointer.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            int_setup <= dma_cmd_pkg::SETUP_RST;
            vector_base <= dma_cmd_pkg::VECTOR_RST;
        end else if (i_ce) begin
            if (wr_setup) begin
                int_setup <= i_wdata;
            end
            if (wr_vector) begin
                vector_base <= i_wdata;
            end
        end
    end

    // Read mux; an unmapped index reads as zero.
    logic [7:0] rd_value;
    always_comb begin
        case (ptr)
            dma_cmd_pkg::IDX_COMMAND: begin
                rd_value = status_flags;
            end
            dma_cmd_pkg::IDX_INT_SETUP: begin
                rd_value = int_setup;
            end
            dma_cmd_pkg::IDX_VECTOR: begin
                rd_value = vector_base;
            end
            dma_cmd_pkg::IDX_CHAN_STATE: begin
                rd_value = {in_service_flag, pending_flag};
            end
            default: begin
                rd_value = dma_cmd_pkg::BYTE_ZERO;
            end
        endcase
    end

    // Data output: one cycle after a read or acknowledge strobe, for one
    // cycle. With no-vector set the bus stays undriven on acknowledge.
    logic [7:0] next_data;
    logic next_data_oe;
    assign next_data_oe = i_rd | (ack_ours & ~no_vector);
    assign next_data = ack_ours ? ack_vector
        : (i_rd ? rd_value : dma_cmd_pkg::BYTE_ZERO);

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_data <= dma_cmd_pkg::BYTE_ZERO;
            o_data_oe <= 1'b0;
        end else if (i_ce) begin
            o_data <= next_data;
            o_data_oe <= next_data_oe;
        end
    end

endmodule

// File: dma_cell_command_interrupt_chk.sv
// Port-level checker for the DMA cell command and interrupt block.
// Assumes a single clock domain and shadows pointer and setup itself.
`timescale 1ns/1ns
module dma_cell_command_interrupt_chk #(
    parameter int CHANNELS = 4
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic i_intack,
    input wire logic i_chain_enable_in,
    input wire logic [3:0] i_tc_event,
    input wire logic [3:0] i_abort_event,
    input wire logic [3:0] i_irq_event,
    input wire logic [7:0] o_data,
    input wire logic o_data_oe,
    input wire logic o_irq,
    input wire logic o_chain_enable_out,
    input wire logic [3:0] o_chan_enable
);
    logic [4:0] ptr; // Shadow of the register pointer.
    logic [7:0] setup; // Shadow of the interrupt setup register.
    wire cmd_wr = i_ce && i_wr && (ptr == 5'h00);
    wire [2:0] code = i_wdata[7:5];

    // Shadow state; any access through a nonzero pointer returns it to 0.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ptr <= 5'h00;
            setup <= 8'h00;
        end else if (i_ce && (i_wr || i_rd)) begin
            ptr <= cmd_wr ? i_wdata[4:0] : 5'h00;
            if (i_wr && ptr == 5'h01) begin
                setup <= i_wdata;
            end
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    AST_NULL_CMD: assert property (cmd_wr && code == 3'h0 |=>
        $stable(o_chan_enable)) else $error("null command changed enables");
    AST_CELL_RESET: assert property (cmd_wr && code == 3'h3 |=>
        o_chan_enable == 4'h0) else $error("cell reset left enables");
    AST_CHAN_EN: assert property (cmd_wr && code[2] |=>
        o_chan_enable == ($past(o_chan_enable) | (4'h1 << $past(code[1:0]))))
        else $error("enable command wrong channel");
    AST_GATE_OFF: assert property (!setup[7] |-> !o_irq)
        else $error("request with gate clear");
    AST_LOWER_BLOCK: assert property (setup[6] |-> !o_chain_enable_out)
        else $error("chain out active while blocked");
    AST_CHAIN_FOLLOW: assert property ((!i_chain_enable_in || o_irq)
        |-> !o_chain_enable_out) else $error("chain out not low");
    AST_READ_ANSWER: assert property (i_ce && i_rd |=> o_data_oe)
        else $error("read not answered");
    AST_NO_VECTOR: assert property (i_ce && i_intack && !i_rd &&
        setup[5] |=> !o_data_oe) else $error("bus driven in no-vector mode");
    AST_ACK_DRIVE: assert property (i_ce && i_intack && o_irq &&
        !setup[5] |=> o_data_oe) else $error("vector not returned");
    AST_OE_CAUSE: assert property (o_data_oe |->
        $past(i_ce && (i_rd || i_intack))) else $error("bus driven unasked");
endmodule

bind dma_cell_command_interrupt dma_cell_command_interrupt_chk #(
    .CHANNELS(CHANNELS)
) u_chk (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_wdata(i_wdata),
    .i_intack(i_intack),
    .i_chain_enable_in(i_chain_enable_in),
    .i_tc_event(i_tc_event),
    .i_abort_event(i_abort_event),
    .i_irq_event(i_irq_event),
    .o_data(o_data),
    .o_data_oe(o_data_oe),
    .o_irq(o_irq),
    .o_chain_enable_out(o_chain_enable_out),
    .o_chan_enable(o_chan_enable)
);

// File: host_bus_model.sv
// Behavioural host processor on the byte-wide register port.
// Assumes one-cycle strobes and a registered one-cycle answer.
`timescale 1ns/1ns
module host_bus_model (
    input wire logic i_clk,
    input wire logic [7:0] i_data,
    input wire logic i_oe,
    output logic o_wr,
    output logic o_rd,
    output logic o_intack,
    output logic [7:0] o_wdata
);
    // Quiet bus at time zero.
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_intack = 1'b0;
        o_wdata = 8'h00;
    end

    // One write strobe; data is inverted after release so stale data
    // can never be mistaken for a held value.
    task automatic wr(input logic [7:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
        #1;
    endtask

    // Read or acknowledge strobe; the answer stands one cycle later.
    task automatic strobe(input bit ack, output logic [7:0] d,
                          output logic oe);
        @(posedge i_clk);
        o_rd <= !ack;
        o_intack <= ack;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_intack <= 1'b0;
        // The answer is registered on the edge that takes the strobe and
        // stands for that one cycle only, so it is read just after it.
        #1;
        d = i_data;
        oe = i_oe;
    endtask

    // Indirect access: load the pointer, then one access.
    task automatic reg_wr(input logic [4:0] idx, input logic [7:0] d);
        wr({3'h0, idx});
        wr(d);
    endtask

    task automatic reg_rd(input logic [4:0] idx, output logic [7:0] d,
                          output logic oe);
        wr({3'h0, idx});
        strobe(1'b0, d, oe);
    endtask
endmodule

// File: tb_dma_cell_command_interrupt.sv
// Self-checking bench for the DMA cell command and interrupt block.
// Assumes the host model above drives the register port.
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    miscompares++; $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); \
    end end
module tb_dma_cell_command_interrupt;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic chain = 1'b1; // Upstream chain enable, open by default.
    logic ce = 1'b1; // Clock enable, dropped once to prove the freeze.
    logic [3:0] tc = 4'h0;
    logic [3:0] ab = 4'h0;
    logic [3:0] irqe = 4'h0;
    logic wr, rd, ack, oe_o, irq, chain_out, oe;
    logic [7:0] wdata, data_o, d;
    logic [3:0] chan_en, exp_en;
    logic [7:0] vec [4] = '{8'hE9, 8'hED, 8'hEB, 8'hEF};
    int miscompares = 0;
    int checks_done = 0;

    always #2 clk = ~clk;

    dma_cell_command_interrupt u_dut (.i_mclk(clk), .i_sys_rst(rst),
        .i_ce(ce), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
        .i_intack(ack), .i_chain_enable_in(chain), .i_tc_event(tc),
        .i_abort_event(ab), .i_irq_event(irqe), .o_data(data_o),
        .o_data_oe(oe_o), .o_irq(irq), .o_chain_enable_out(chain_out),
        .o_chan_enable(chan_en));

    host_bus_model u_host (.i_clk(clk), .i_data(data_o), .i_oe(oe_o),
        .o_wr(wr), .o_rd(rd), .o_intack(ack), .o_wdata(wdata));

    // One-cycle datapath event pulses.
    task automatic ev(input logic [3:0] t, a, q);
        @(posedge clk);
        tc <= t;
        ab <= a;
        irqe <= q;
        @(posedge clk);
        tc <= 4'h0;
        ab <= 4'h0;
        irqe <= 4'h0;
        #1;
    endtask

    // Indirect read with expected byte; index 0 reads the status.
    task automatic rr(input logic [4:0] idx, input logic [7:0] exp);
        u_host.reg_rd(idx, d, oe);
        `CHK(oe, 1'b1)
        `CHK(d, exp)
    endtask

    // Acknowledge with expected drive and vector.
    task automatic ak(input logic exp_oe, input logic [7:0] exp);
        u_host.strobe(1'b1, d, oe);
        `CHK(oe, exp_oe)
        if (exp_oe) `CHK(d, exp)
    endtask

    task automatic results();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch.
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        results();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rr(5'h01, 8'h00);
        rr(5'h00, 8'h00);
        `CHK({irq, chain_out, chan_en}, 6'h10)
        // Null and reserved codes leave the enables alone.
        u_host.wr(8'h00);
        u_host.wr(8'h20);
        `CHK(chan_en, 4'h0)
        exp_en = 4'h0;
        for (int c = 4; c < 8; c++) begin
            u_host.wr({c[2:0], 5'h00});
            exp_en[c - 4] = 1'b1;
            `CHK(chan_en, exp_en)
        end
        u_host.wr(8'h60);
        `CHK(chan_en, 4'h0)
        ev(4'hA, 4'h5, 4'h0);
        rr(5'h00, 8'hA5);
        rr(5'h00, 8'h00);
        u_host.reg_wr(5'h02, 8'hE1);
        rr(5'h02, 8'hE1);
        u_host.reg_wr(5'h01, 8'h1F);
        ev(4'h0, 4'h0, 4'hF);
        `CHK(irq, 1'b0)
        u_host.reg_wr(5'h01, 8'h9F);
        rr(5'h01, 8'h9F);
        `CHK({irq, chain_out}, 2'b10)
        // Four acks walk the fixed priority with status codes.
        for (int i = 0; i < 4; i++) begin
            ak(1'b1, vec[i]);
        end
        `CHK({irq, chain_out}, 2'b00)
        @(posedge clk) chain <= 1'b0;
        u_host.wr(8'h40);
        rr(5'h03, 8'h70);
        @(posedge clk) chain <= 1'b1;
        repeat (3) u_host.wr(8'h40);
        rr(5'h03, 8'h00);
        `CHK(chain_out, 1'b1)
        u_host.reg_wr(5'h01, 8'h8F);
        ev(4'h0, 4'h0, 4'h2);
        ak(1'b1, 8'hE1);
        u_host.reg_wr(5'h01, 8'hAF);
        ev(4'h0, 4'h0, 4'h1);
        ak(1'b0, 8'h00);
        repeat (2) u_host.wr(8'h40);
        u_host.reg_wr(5'h01, 8'hCF);
        `CHK(chain_out, 1'b0)
        u_host.reg_wr(5'h01, 8'h8F);
        `CHK(chain_out, 1'b1)
        // A low clock enable loses both a command strobe and status events.
        @(posedge clk) ce <= 1'b0;
        u_host.wr(8'hE0);
        ev(4'hF, 4'hF, 4'h0);
        @(posedge clk) ce <= 1'b1;
        #1;
        `CHK(chan_en, 4'h0)
        rr(5'h00, 8'h00);
        // A closed chain refuses the acknowledge.
        @(posedge clk) chain <= 1'b0;
        ev(4'h0, 4'h0, 4'h8);
        ak(1'b0, 8'h00);
        rr(5'h03, 8'h08);
        @(posedge clk) chain <= 1'b1;
        #1;
        `CHK(irq, 1'b1)
        u_host.wr(8'hE0);
        u_host.wr(8'h60);
        `CHK(chan_en, 4'h0)
        rr(5'h03, 8'h00);
        results();
    end
endmodule
